// ===== include/flash_seq_pkg.sv
// register map, field layout and carrier types for the flash sequencer block
// Functional notes
// - security word bit 12 reports the write-prohibit flag
// - security word bit 10 reports the block-erase-prohibit flag
// - security word bit 9 reports the boot-rewrite-prohibit flag
// - security word bit 3 reports the read-protect flag
// - security word bit 8 is boot swap: 0 cluster 1, 1 cluster 0
// - window start register holds first protected block in bits 8..0
// - window end register holds last window block plus one in bits 8..0
// - window end bit 15 selects mode: 1 outside, 0 inside
// - window start bit 15 is protection: 1 disabled, 0 enabled
// - after reset both window block fields read 511
// - area select written 0x00 targets code/data area, not extra area
// - erase covers one 2 KB block from pointer and end address registers
// - writing 0x84 to the command register starts the erase
// - init control pulsed 1 then 0 clears controls, keeps error status
// - error status bits: 5 extra, 4 code/data, 3 blank, 1 write, 0 erase
package flash_seq_pkg;
   localparam logic [7:0] OFF_SEC      = 8'h00;
   localparam logic [7:0] OFF_WIN_STRT = 8'h04;
   localparam logic [7:0] OFF_WIN_END  = 8'h08;
   localparam logic [7:0] OFF_AREA     = 8'h0c;
   localparam logic [7:0] OFF_CMD      = 8'h10;
   localparam logic [7:0] OFF_PTR_LO   = 8'h14;
   localparam logic [7:0] OFF_PTR_HI   = 8'h18;
   localparam logic [7:0] OFF_END_LO   = 8'h1c;
   localparam logic [7:0] OFF_END_HI   = 8'h20;
   localparam logic [7:0] OFF_INIT     = 8'h24;
   localparam logic [7:0] OFF_ERR      = 8'h28;
   localparam logic [7:0] OFF_STAT     = 8'h2c;

   localparam int SEC_WP     = 12;
   localparam int SEC_BLOCK_ERASE_PROHIBIT_FLAG   = 10;
   localparam int SEC_BOOTRW = 9;
   localparam int SEC_SWAP   = 8;
   localparam int SEC_RDPR   = 3;
   localparam logic [15:0] SEC_MASK = 16'h1708;
   localparam logic [15:0] SEC_RST  = 16'h0000;

   localparam int WIN_FLAG = 15;
   localparam logic [15:0] WIN_MASK = 16'h81ff;
   localparam logic [8:0]  BLK_RST  = 9'h1ff;
   localparam logic [15:0] WIN_RST  = 16'h01ff;

   localparam int CMD_START = 7;
   localparam logic [2:0] MODE_ERASE = 3'h4;
   localparam logic [7:0] CMD_ERASE  = 8'h84;
   localparam logic [7:0] CMD_MASK   = 8'h87;
   localparam logic [7:0] CMD_RST    = 8'h00;

   localparam int ERR_ERASE = 0;
   localparam int ERR_WRITE = 1;
   localparam int ERR_BLANK = 3;
   localparam int ERR_CD    = 4;
   localparam int ERR_EXTRA = 5;
   localparam logic [5:0] ERR_RST = 6'h00;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ERASE = 2'b01,
      ST_DONE  = 2'b11
   } seq_state_e;

   typedef struct packed {
      logic [15:0] sec;
      logic [15:0] win_start;
      logic [15:0] win_end;
   } nvm_flags_s;

   typedef struct packed {
      logic        erase_req;
      logic [23:0] start_addr;
      logic [23:0] end_addr;
   } array_req_s;

   typedef struct packed {
      logic done;
      logic erase_err;
      logic write_err;
      logic blank_err;
      logic extra_err;
   } array_rsp_s;
endpackage

// ===== verilog/flash_seq.sv
// flash sequencer: flag/window readout, block erase launch, ahb-lite registers
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_seq (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      ce,
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic                           hreadyout,
   output logic                           hresp,
   output logic [31:0]                    hrdata,
   input  wire flash_seq_pkg::nvm_flags_s nvm,
   output flash_seq_pkg::array_req_s      arr_req,
   input  wire flash_seq_pkg::array_rsp_s arr_rsp,
   output logic                           busy
);
   logic                     wr_q;
   logic                     rd_q;
   logic [7:0]               addr_q;
   logic [31:0]              hrdata_q;
   logic [31:0]              rdata;
   logic                     addr_ok;
   logic                     start_ok;
   logic                     refused;
   flash_seq_pkg::seq_state_e state_q;
   logic [15:0]              sec_q;
   logic [15:0]              ws_q;
   logic [15:0]              we_q;
   logic                     area_q;
   logic [7:0]               cmd_q;
   logic [15:0]              ptr_lo_q;
   logic [7:0]               ptr_hi_q;
   logic [15:0]              end_lo_q;
   logic [7:0]               end_hi_q;
   logic                     init_q;
   logic [5:0]               err_q;
   logic [5:0]               err_d;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // ---------------- bus slave ----------------
   // hsize is not checked: only whole-word single transfers are issued
   assign addr_ok = hsel & htrans[1] & hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 8'h00;
      end else if (ce) begin
         wr_q <= addr_ok & hwrite;
         rd_q <= addr_ok & ~hwrite;
         if (addr_ok) begin
            addr_q <= haddr[7:0];
         end
      end
   end

   // reads take one wait state so the data word comes from a flop
   // and sees any write that completed in the cycle before
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (ce && rd_q) begin
         hrdata_q <= rdata;
      end
   end

   assign hreadyout = ~rd_q;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   always_comb begin
      rdata = 32'h0000_0000;
      unique case (1'b1)
         hit(addr_q, flash_seq_pkg::OFF_SEC):      rdata[15:0] = sec_q;
         hit(addr_q, flash_seq_pkg::OFF_WIN_STRT): rdata[15:0] = ws_q;
         hit(addr_q, flash_seq_pkg::OFF_WIN_END):  rdata[15:0] = we_q;
         hit(addr_q, flash_seq_pkg::OFF_AREA):     rdata[0]    = area_q;
         hit(addr_q, flash_seq_pkg::OFF_CMD):      rdata[7:0]  = cmd_q;
         hit(addr_q, flash_seq_pkg::OFF_PTR_LO):   rdata[15:0] = ptr_lo_q;
         hit(addr_q, flash_seq_pkg::OFF_PTR_HI):   rdata[7:0]  = ptr_hi_q;
         hit(addr_q, flash_seq_pkg::OFF_END_LO):   rdata[15:0] = end_lo_q;
         hit(addr_q, flash_seq_pkg::OFF_END_HI):   rdata[7:0]  = end_hi_q;
         hit(addr_q, flash_seq_pkg::OFF_INIT):     rdata[0]    = init_q;
         hit(addr_q, flash_seq_pkg::OFF_ERR):      rdata[5:0]  = err_q;
         hit(addr_q, flash_seq_pkg::OFF_STAT):     rdata[0]    = busy;
         default:                                  rdata       = 32'h0000_0000;
      endcase
   end

   // ---------------- flag and window snapshot ----------------
   // snapshot frozen while a command runs, so a read never tears
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sec_q <= flash_seq_pkg::SEC_RST;
         ws_q  <= flash_seq_pkg::WIN_RST;
         we_q  <= flash_seq_pkg::WIN_RST;
      end else if (ce && state_q == flash_seq_pkg::ST_IDLE) begin
         sec_q <= nvm.sec & flash_seq_pkg::SEC_MASK;
         ws_q  <= nvm.win_start & flash_seq_pkg::WIN_MASK;
         we_q  <= nvm.win_end & flash_seq_pkg::WIN_MASK;
      end
   end

   // ---------------- control registers ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_q <= 1'b0;
      end else if (ce && wr_q && hit(addr_q, flash_seq_pkg::OFF_INIT)) begin
         init_q <= hwdata[0];
      end
   end

   // init control holds every control register clear; error status survives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         area_q   <= 1'b0;
         ptr_lo_q <= 16'h0000;
         ptr_hi_q <= 8'h00;
         end_lo_q <= 16'h0000;
         end_hi_q <= 8'h00;
      end else if (ce) begin
         if (init_q) begin
            area_q   <= 1'b0;
            ptr_lo_q <= 16'h0000;
            ptr_hi_q <= 8'h00;
            end_lo_q <= 16'h0000;
            end_hi_q <= 8'h00;
         end else if (wr_q) begin
            if (hit(addr_q, flash_seq_pkg::OFF_AREA)) begin
               area_q <= hwdata[0];
            end
            if (hit(addr_q, flash_seq_pkg::OFF_PTR_LO)) begin
               ptr_lo_q <= hwdata[15:0];
            end
            if (hit(addr_q, flash_seq_pkg::OFF_PTR_HI)) begin
               ptr_hi_q <= hwdata[7:0];
            end
            if (hit(addr_q, flash_seq_pkg::OFF_END_LO)) begin
               end_lo_q <= hwdata[15:0];
            end
            if (hit(addr_q, flash_seq_pkg::OFF_END_HI)) begin
               end_hi_q <= hwdata[7:0];
            end
         end
      end
   end

   // a start is honoured only when idle; software must not rely on this
   assign start_ok = wr_q & hit(addr_q, flash_seq_pkg::OFF_CMD) & ~init_q
                   & hwdata[flash_seq_pkg::CMD_START]
                   & (hwdata[2:0] == flash_seq_pkg::MODE_ERASE)
                   & ~area_q
                   & (state_q == flash_seq_pkg::ST_IDLE);
   assign refused  = sec_q[flash_seq_pkg::SEC_BLOCK_ERASE_PROHIBIT_FLAG];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_q <= flash_seq_pkg::CMD_RST;
      end else if (ce) begin
         if (init_q) begin
            cmd_q <= flash_seq_pkg::CMD_RST;
         end else if (wr_q && hit(addr_q, flash_seq_pkg::OFF_CMD) && !busy) begin
            cmd_q <= hwdata[7:0] & flash_seq_pkg::CMD_MASK;
         end else if (state_q == flash_seq_pkg::ST_DONE) begin
            cmd_q[flash_seq_pkg::CMD_START] <= 1'b0;
         end
      end
   end

   // ---------------- erase sequencer ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= flash_seq_pkg::ST_IDLE;
      end else if (ce) begin
         unique case (state_q)
            flash_seq_pkg::ST_IDLE: begin
               if (start_ok && !refused) begin
                  state_q <= flash_seq_pkg::ST_ERASE;
               end
            end
            flash_seq_pkg::ST_ERASE: begin
               if (arr_rsp.done) begin
                  state_q <= flash_seq_pkg::ST_DONE;
               end
            end
            flash_seq_pkg::ST_DONE: begin
               state_q <= flash_seq_pkg::ST_IDLE;
            end
            default: begin
               state_q <= flash_seq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign busy                = state_q != flash_seq_pkg::ST_IDLE;
   assign arr_req.erase_req   = state_q == flash_seq_pkg::ST_ERASE;
   assign arr_req.start_addr  = {ptr_hi_q, ptr_lo_q};
   assign arr_req.end_addr    = {end_hi_q, end_lo_q};

   // error status: a new start clears, but a hardware set in the same
   // cycle still wins
   always_comb begin
      err_d = start_ok ? flash_seq_pkg::ERR_RST : err_q;
      if (start_ok && refused) begin
         err_d[flash_seq_pkg::ERR_ERASE] = 1'b1;
         err_d[flash_seq_pkg::ERR_CD]    = 1'b1;
      end
      if (state_q == flash_seq_pkg::ST_ERASE) begin
         if (arr_rsp.erase_err) begin
            err_d[flash_seq_pkg::ERR_ERASE] = 1'b1;
         end
         if (arr_rsp.write_err) begin
            err_d[flash_seq_pkg::ERR_WRITE] = 1'b1;
         end
         if (arr_rsp.blank_err) begin
            err_d[flash_seq_pkg::ERR_BLANK] = 1'b1;
         end
         if (arr_rsp.erase_err || arr_rsp.write_err || arr_rsp.blank_err) begin
            err_d[flash_seq_pkg::ERR_CD] = 1'b1;
         end
      end
      if (arr_rsp.extra_err) begin
         err_d[flash_seq_pkg::ERR_EXTRA] = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_q <= flash_seq_pkg::ERR_RST;
      end else if (ce) begin
         err_q <= err_d;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   win_reset_a: assert property (
      $rose(hresetn) |-> ws_q[8:0] == 9'h1ff && we_q[8:0] == 9'h1ff)
      else $error("window fields not 511 after reset");

   wp_track_a: assert property (
      ce && state_q == flash_seq_pkg::ST_IDLE |=> sec_q[12] == $past(nvm.sec[12]))
      else $error("write-prohibit bit not reported in bit 12");

   boot_swap_a: assert property (
      ce && state_q == flash_seq_pkg::ST_IDLE |=> sec_q[8] == $past(nvm.sec[8]))
      else $error("boot swap bit not reported in bit 8");

   sec_zero_a: assert property (
      (sec_q & 16'he8f7) == 16'h0000)
      else $error("unassigned security bit reads nonzero");

   snap_hold_a: assert property (
      ce && busy |=> $stable(sec_q) && $stable(ws_q) && $stable(we_q))
      else $error("flag snapshot moved during a command");

   win_mode_a: assert property (
      ce && state_q == flash_seq_pkg::ST_IDLE |=> we_q[15] == $past(nvm.win_end[15]))
      else $error("window mode bit not in end register bit 15");

   area_gate_a: assert property (
      $rose(arr_req.erase_req) |-> !$past(area_q) && $past(wr_q))
      else $error("erase launched with extra area selected");

   erase_go_a: assert property (
      ce && wr_q && addr_q == 8'h10 && hwdata[7:0] == 8'h84 && !busy && !area_q
      && !init_q && !sec_q[10] |=> arr_req.erase_req ##1 !$fell(arr_req.erase_req))
      else $error("command 0x84 did not start an erase");

   erase_ban_a: assert property (
      ce && start_ok && sec_q[10] |=> !busy && err_q[0] && err_q[4])
      else $error("erase-prohibit flag did not refuse the erase");

   init_clr_a: assert property (
      ce && init_q |=> cmd_q == 8'h00 && !area_q && ptr_lo_q == 16'h0000)
      else $error("init control did not clear control registers");

   err_set_a: assert property (
      ce && state_q == flash_seq_pkg::ST_ERASE && arr_rsp.erase_err |=> err_q[0] && err_q[4])
      else $error("erase error not reported in bits 0 and 4");

   // a low enable must hold the sequencer state, error status, command, init control and security snapshot
   ce_freeze_a: assert property (
      !ce |=> $stable(state_q) && $stable(err_q) && $stable(cmd_q) && $stable(init_q)
      && $stable(sec_q))
      else $error("state moved while clock enable was low");

   block_erase_prohibit_flag_track_a: assert property (
      ce && state_q == flash_seq_pkg::ST_IDLE |=> sec_q[10] == $past(nvm.sec[10]))
      else $error("erase-prohibit bit not reported in bit 10");

   boot_rw_a: assert property (
      ce && state_q == flash_seq_pkg::ST_IDLE |=> sec_q[9] == $past(nvm.sec[9]))
      else $error("boot-rewrite-prohibit bit not reported in bit 9");

   read_prot_a: assert property (
      ce && state_q == flash_seq_pkg::ST_IDLE |=> sec_q[3] == $past(nvm.sec[3]))
      else $error("read-protect bit not reported in bit 3");

   win_first_a: assert property (
      ce && state_q == flash_seq_pkg::ST_IDLE |=> ws_q[8:0] == $past(nvm.win_start[8:0]))
      else $error("window start block not in bits 8 to 0");

   win_last_a: assert property (
      ce && state_q == flash_seq_pkg::ST_IDLE |=> we_q[8:0] == $past(nvm.win_end[8:0]))
      else $error("window end block not in bits 8 to 0");

   win_prot_a: assert property (
      ce && state_q == flash_seq_pkg::ST_IDLE |=> ws_q[15] == $past(nvm.win_start[15]))
      else $error("window protection bit not in start register bit 15");

   win_upper_a: assert property (
      ws_q[14:9] == 6'h00 && we_q[14:9] == 6'h00)
      else $error("window register bits 14 to 9 read nonzero");

   erase_hold_a: assert property (
      arr_req.erase_req && !arr_rsp.done |=> arr_req.erase_req)
      else $error("erase request dropped before the array finished");

   done_clear_a: assert property (
      ce && state_q == flash_seq_pkg::ST_DONE |=> !busy && !cmd_q[7])
      else $error("start bit or busy not cleared after the erase");

   extra_err_a: assert property (
      ce && arr_rsp.extra_err |=> err_q[5])
      else $error("extra area error not reported in bit 5");

   init_keep_a: assert property (
      ce && init_q && !arr_rsp.extra_err && state_q == flash_seq_pkg::ST_IDLE
      |=> err_q == $past(err_q))
      else $error("init control disturbed the error status");
endmodule
`default_nettype wire

// ===== tb/flash_array_model.sv
// behavioural code flash array facing the sequencer: flag words and erase answers
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire flash_seq_pkg::array_req_s  arr_req,
   input  wire logic [47:0]                flags,
   input  wire logic [7:0]                 lat,
   input  wire logic [3:0]                 fail,
   output flash_seq_pkg::nvm_flags_s       nvm,
   output flash_seq_pkg::array_rsp_s       arr_rsp
);
   logic [7:0] cnt_q;

   // bench holds 511 in both window fields until a test changes them
   assign nvm = flags;
   // lat sets how slow the erase is; fail bits 0..3 give erase, write,
   // blank and extra errors, all sent with done
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q   <= 8'h00;
         arr_rsp <= '0;
      end else begin
         arr_rsp <= '0;
         if (arr_req.erase_req && !arr_rsp.done) begin
            if (cnt_q == lat) begin
               cnt_q             <= 8'h00;
               arr_rsp.done      <= 1'b1;
               arr_rsp.erase_err <= fail[0];
               arr_rsp.write_err <= fail[1];
               arr_rsp.blank_err <= fail[2];
               arr_rsp.extra_err <= fail[3];
            end else begin
               cnt_q <= cnt_q + 8'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench: ahb-lite register traffic, flag readout and block erase
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                      hclk = 1'b0;
   logic                      hresetn = 1'b0;
   logic                      hsel = 1'b0;
   logic [31:0]               haddr = 32'h0;
   logic [1:0]                htrans = 2'b00;
   logic                      hwrite = 1'b0;
   logic [31:0]               hwdata = 32'h0;
   logic                      hreadyout;
   logic                      hresp;
   logic [31:0]               hrdata;
   logic                      busy;
   logic [47:0]               flags = {16'h0000, 16'h01ff, 16'h01ff};
   logic [7:0]                lat = 8'h00;
   logic [3:0]                fail = 4'h0;
   logic                      ce = 1'b1;
   flash_seq_pkg::nvm_flags_s nvm;
   flash_seq_pkg::array_req_s arr_req;
   flash_seq_pkg::array_rsp_s arr_rsp;
   int unsigned               mdl[int];
   int                        n_fail = 0;
   int                        checked = 0;

   always #12.5 hclk = ~hclk;

   flash_seq u_flash_seq (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .nvm(nvm), .arr_req(arr_req), .arr_rsp(arr_rsp), .busy(busy));
   flash_array_model u_flash_array_model (.hclk(hclk), .hresetn(hresetn), .arr_req(arr_req),
      .flags(flags), .lat(lat), .fail(fail), .nvm(nvm), .arr_rsp(arr_rsp));

   task automatic give_verdict;
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // writable bits per offset; zero means read-only or unmapped
   function automatic logic [31:0] msk(input logic [7:0] a);
      case (a)
         8'h0c, 8'h24: return 32'h1;
         8'h10: return 32'h87;
         8'h14, 8'h1c: return 32'hffff;
         8'h18, 8'h20: return 32'hff;
         default: return 32'h0;
      endcase
   endfunction

   // entered and left just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
      if (mdl[36] == 1 && a != 8'h24) return;
      if (msk(a) != 0) mdl[a] = d & msk(a);
      if (a == 8'h24 && d[0]) for (int k = 12; k <= 32; k += 4) mdl[k] = 0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m = 32'hffffffff);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r & m, (mdl.exists(a) ? mdl[a] : 32'h0) & m);
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic put_flags(input logic [15:0] s, input logic [15:0] ws, input logic [15:0] we);
      flags <= {s, ws, we};
      mdl[0] = s & flash_seq_pkg::SEC_MASK;
      mdl[4] = ws & flash_seq_pkg::WIN_MASK;
      mdl[8] = we & flash_seq_pkg::WIN_MASK;
      repeat (2) @(posedge hclk);
   endtask

   // go: start expected; prohibited starts report erase and code/data errors
   task automatic erase(input logic [8:0] blk, input logic [7:0] dly, input logic [3:0] bad,
                        input logic go);
      logic [23:0] st;
      int          n;
      st = {4'h0, blk, 11'h000};
      lat <= dly;
      fail <= bad;
      wr(8'h0c, 32'h0);
      wr(8'h14, {16'h0, st[15:0]});
      wr(8'h18, {24'h0, st[23:16]});
      wr(8'h1c, {16'h0, st[15:0] | 16'h07ff});
      wr(8'h20, {24'h0, st[23:16]});
      wr(8'h10, 32'h84);
      #1;
      chk({31'h0, arr_req.erase_req}, {31'h0, go});
      if (go) chk({8'h0, arr_req.start_addr}, {8'h0, st});
      if (go) chk({8'h0, arr_req.end_addr}, {8'h0, st + 24'h7ff});
      @(posedge hclk);
      n = 0;
      while (busy !== 1'b0 && n < 400) begin
         @(posedge hclk);
         n++;
      end
      chk({31'h0, busy}, 32'h0);
      mdl[40] = go ? {26'h0, bad[3], |bad[2:0], bad[2], 1'b0, bad[1:0]} : 32'h11;
      rd(8'h28);
      mdl[16] = go ? 32'h04 : 32'h84;
      rd(8'h10);
   endtask

   initial begin
      void'($urandom(32'h825b));
      for (int a = 0; a < 48; a += 4) mdl[a] = 0;
      mdl[4] = 32'h1ff;
      mdl[8] = 32'h1ff;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(8'h04);
      rd(8'h08);
      for (int i = 0; i < 6; i++) begin
         if (i == 0) put_flags(16'hffff, 16'hffff, 16'hffff);
         else put_flags(16'($urandom), 16'($urandom), 16'($urandom));
         rd(8'h00);
         wr(8'h00, $urandom);
         rd(8'h00);
         rd(8'h04);
         rd(8'h08);
      end
      rd(8'h30);
      // snapshot must not follow the flag words while clock enable is low
      ce <= 1'b0;
      put_flags(16'h0000, 16'h01ff, 16'h01ff);
      ce <= 1'b1;
      rd(8'h00);
      erase(9'h1ff, 8'h00, 4'h0, 1'b1);
      erase(9'($urandom), 8'h14, 4'h1, 1'b1);
      erase(9'($urandom), 8'h05, 4'h0, 1'b1);
      erase(9'($urandom), 8'h05, 4'he, 1'b1);
      put_flags(16'h0400, 16'h01ff, 16'h01ff);
      erase(9'h000, 8'h00, 4'h0, 1'b0);
      wr(8'h0c, 32'h1);
      wr(8'h10, 32'h84);
      #1;
      chk({30'h0, busy, arr_req.erase_req}, 32'h0);
      @(posedge hclk);
      wr(8'h24, 32'h1);
      wr(8'h14, $urandom);
      wr(8'h24, 32'h0);
      for (int k = 12; k <= 32; k += 4) rd(k[7:0]);
      rd(8'h28);
      rd(8'h2c);
      give_verdict();
   end

   // whole sequence needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      give_verdict();
   end
endmodule
`default_nettype wire
